//--- src/conv_pkg.sv
package conv_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] CONTROL_IDX      = 8'h00;
    localparam logic [7:0] VALUE_IDX        = 8'h01;
    localparam int         ADDR_SHIFT       = 2;
    localparam int         RUN_STBY_BIT     = 7;
    localparam int         PIN_BUF_BIT      = 6;
    localparam int         ENABLE_BIT       = 0;
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] VALUE_RESET      = 8'h00;
    localparam logic [7:0] CONTROL_MASK     = 8'hc1;
    // settling time of the string and buffer after power-up
    localparam int         STARTUP_NS       = 2000;
    localparam int         CLK_PERIOD_NS    = 20;
    localparam int         STARTUP_CYCLES   =
        (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY        = 2'b00;
    localparam logic [1:0] RESP_SLVERR      = 2'b10;
    typedef enum logic [1:0] {
        PWR_OFF   = 2'b00,
        PWR_START = 2'b01,
        PWR_RUN   = 2'b11
    } pwr_state_t;
endpackage : conv_pkg

//--- src/dac_control_logic.sv
`timescale 1ns/10ps
`default_nettype none

module dac_control_logic #(
    parameter int STARTUP_CYCLES = conv_pkg::STARTUP_CYCLES
) (
    input  wire logic        MCLK,
    input  wire logic        SRST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        STANDBY_SLEEP,
    input  wire logic        POWERDOWN_SLEEP,
    input  wire logic        DEBUG_HALT,
    output logic             CONVERTER_POWER,
    output logic             BUFFER_POWER,
    output logic             PIN_DRIVE_EN,
    output logic             INTERNAL_OUT_VALID,
    output logic [7:0]       CONVERT_CODE,
    output logic             CONVERT_START
);
    // the start-up counter is 16 bits wide and must count at least once
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_bad_startup
        $error("STARTUP_CYCLES out of range");
    end

    logic [7:0]  control_r;
    logic [7:0]  value_r;
    logic [7:0]  aw_addr_r;
    logic        aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_have_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        wr_fire;
    logic [7:0]  wr_idx;
    logic        wr_ctrl;
    logic        wr_val;
    logic [7:0]  rd_idx;
    logic        enable;
    logic        power_ok;
    logic        pending_r;
    logic [15:0] start_cnt_r;
    logic [7:0]  code_r;
    logic        start_r;
    conv_pkg::pwr_state_t state_r;
    conv_pkg::pwr_state_t state_nxt;
    logic        fire_start;
    logic        wr_mapped;
    logic        pin_buf;
    logic        run_stby;

    // write address and data are taken in either order, one write at a time
    assign S_AXI_AWREADY = !aw_have_r && !bvalid_r;
    assign S_AXI_WREADY  = !w_have_r && !bvalid_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID  = rvalid_r;
    assign S_AXI_RDATA   = rdata_r;
    assign S_AXI_RRESP   = rresp_r;

    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wr_idx  = {2'b00, aw_addr_r[7:2]};
    assign wr_ctrl = wr_fire && w_strb_r[0]
                     && wr_idx == conv_pkg::CONTROL_IDX;
    assign wr_val  = wr_fire && w_strb_r[0]
                     && wr_idx == conv_pkg::VALUE_IDX;
    assign rd_idx  = {2'b00, S_AXI_ARADDR[7:2]};
    // only two words are decoded; every other offset is an error
    assign wr_mapped = wr_idx == conv_pkg::CONTROL_IDX
                       || wr_idx == conv_pkg::VALUE_IDX;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            aw_have_r <= 1'b0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_r <= 1'b1;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            aw_addr_r <= 8'h00;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_addr_r <= S_AXI_AWADDR;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            w_have_r <= 1'b0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_r <= 1'b1;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bvalid_r <= 1'b0;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
        end else if (bvalid_r && S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // unmapped offsets answer with an error and leave all state alone
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bresp_r <= conv_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            if (wr_mapped) begin
                bresp_r <= conv_pkg::RESP_OKAY;
            end else begin
                bresp_r <= conv_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rvalid_r <= 1'b0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_r <= 1'b1;
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= conv_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            if (rd_idx == conv_pkg::CONTROL_IDX) begin
                rdata_r <= {24'h000000, control_r};
                rresp_r <= conv_pkg::RESP_OKAY;
            end else if (rd_idx == conv_pkg::VALUE_IDX) begin
                rdata_r <= {24'h000000, value_r};
                rresp_r <= conv_pkg::RESP_OKAY;
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= conv_pkg::RESP_SLVERR;
            end
        end
    end

    // software orders reference, consumers, data, enable; not checked here
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            control_r <= conv_pkg::CONTROL_RESET;
        end else if (wr_ctrl) begin
            control_r <= w_data_r[7:0] & conv_pkg::CONTROL_MASK;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            value_r <= conv_pkg::VALUE_RESET;
        end else if (wr_val) begin
            value_r <= w_data_r[7:0];
        end
    end

    assign enable = control_r[conv_pkg::ENABLE_BIT];
    assign pin_buf = control_r[conv_pkg::PIN_BUF_BIT];
    assign run_stby = control_r[conv_pkg::RUN_STBY_BIT];
    // debug halt is deliberately not an input term here
    assign power_ok = !POWERDOWN_SLEEP
        && (!STANDBY_SLEEP
            || run_stby);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            conv_pkg::PWR_OFF: begin
                if (enable && power_ok) begin
                    state_nxt = conv_pkg::PWR_START;
                end
            end
            conv_pkg::PWR_START: begin
                if (!enable || !power_ok) begin
                    state_nxt = conv_pkg::PWR_OFF;
                end else if (start_cnt_r == 16'h0001) begin
                    state_nxt = conv_pkg::PWR_RUN;
                end
            end
            conv_pkg::PWR_RUN: begin
                if (!enable || !power_ok) begin
                    state_nxt = conv_pkg::PWR_OFF;
                end
            end
            default: state_nxt = conv_pkg::PWR_OFF;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_r <= conv_pkg::PWR_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            start_cnt_r <= 16'h0000;
        end else if (state_r != conv_pkg::PWR_START) begin
            start_cnt_r <= 16'(STARTUP_CYCLES);
        end else if (start_cnt_r != 16'h0000) begin
            start_cnt_r <= start_cnt_r - 16'h0001;
        end
    end

    // a start needs the converter to stay up through the pulse
    assign fire_start = pending_r && !start_r
                        && state_r == conv_pkg::PWR_RUN
                        && state_nxt == conv_pkg::PWR_RUN;

    // a conversion is owed after enabling or after a value write while enabled
    // cleared as the pulse is issued, so a write in that cycle is kept
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pending_r <= 1'b0;
        end else if (wr_val && enable) begin
            pending_r <= 1'b1;
        end else if (state_r == conv_pkg::PWR_START
                     && state_nxt == conv_pkg::PWR_RUN) begin
            pending_r <= 1'b1;
        end else if (fire_start) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            start_r <= 1'b0;
        end else begin
            start_r <= fire_start;
        end
    end

    // the code is frozen at the start so a later write waits its turn
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            code_r <= 8'h00;
        end else if (fire_start) begin
            code_r <= value_r;
        end
    end

    // powers follow the next state so they line up with state_r
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            CONVERTER_POWER <= 1'b0;
        end else begin
            CONVERTER_POWER <= state_nxt != conv_pkg::PWR_OFF;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            BUFFER_POWER <= 1'b0;
        end else begin
            BUFFER_POWER <= state_nxt != conv_pkg::PWR_OFF
                && pin_buf;
        end
    end

    // pin stays off until start-up ends, so no unsettled level escapes
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            PIN_DRIVE_EN <= 1'b0;
        end else begin
            PIN_DRIVE_EN <= state_nxt == conv_pkg::PWR_RUN
                && pin_buf;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            INTERNAL_OUT_VALID <= 1'b0;
        end else begin
            INTERNAL_OUT_VALID <= state_nxt == conv_pkg::PWR_RUN;
        end
    end

    assign CONVERT_CODE  = code_r;
    assign CONVERT_START = start_r;

endmodule : dac_control_logic

`default_nettype wire

//--- verification/dac_control_logic_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dac_control_logic_props (
    input wire logic        MCLK,
    input wire logic        SRST,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        POWERDOWN_SLEEP,
    input wire logic        CONVERTER_POWER,
    input wire logic        BUFFER_POWER,
    input wire logic        PIN_DRIVE_EN,
    input wire logic        INTERNAL_OUT_VALID,
    input wire logic        CONVERT_START
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    property p_pin; PIN_DRIVE_EN |-> BUFFER_POWER; endproperty
    a_pin: assert property (p_pin)
        else $error("pin driven with buffer unpowered");
    property p_int; INTERNAL_OUT_VALID |-> CONVERTER_POWER; endproperty
    a_int: assert property (p_int)
        else $error("internal output valid while unpowered");
    property p_pd;
        POWERDOWN_SLEEP ##1 POWERDOWN_SLEEP
            |-> !CONVERTER_POWER && !BUFFER_POWER;
    endproperty
    a_pd: assert property (p_pd)
        else $error("powered during power down sleep");
    property p_start; CONVERT_START |-> INTERNAL_OUT_VALID; endproperty
    a_start: assert property (p_start)
        else $error("conversion before start-up done");
    property p_once; CONVERT_START |=> !CONVERT_START; endproperty
    a_once: assert property (p_once)
        else $error("start pulse longer than one cycle");
    property p_b; S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    a_b: assert property (p_b) else $error("write response dropped");
    property p_r; S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r: assert property (p_r) else $error("read response dropped");
    property p_hi; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == '0; endproperty
    a_hi: assert property (p_hi)
        else $error("upper read data not zero");
    property p_ar; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_ar: assert property (p_ar) else $error("read response repeated");
    c_start: cover property (CONVERT_START);
    c_pin: cover property (PIN_DRIVE_EN);
    c_err: cover property (S_AXI_RVALID
        && S_AXI_RRESP == conv_pkg::RESP_SLVERR);
endmodule : dac_control_logic_props
bind dac_control_logic dac_control_logic_props u_props (.*);
`default_nettype wire

//--- verification/dac_control_logic_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dac_control_logic_tb;
    logic MCLK = '0, SRST = '1, S_AXI_AWVALID = '0, S_AXI_WVALID = '0;
    logic S_AXI_BREADY = '0, S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
    logic STANDBY_SLEEP = '0, POWERDOWN_SLEEP = '0, DEBUG_HALT = '0;
    logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, CONVERT_CODE, code;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rdat;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rrsp, brsp;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, CONVERTER_POWER, BUFFER_POWER, PIN_DRIVE_EN;
    logic INTERNAL_OUT_VALID, CONVERT_START;
    int fail_count = 0, comparisons = 0, starts = 0, cyc = 0;
    // short start-up keeps the run brief; waits below allow for it
    dac_control_logic #(.STARTUP_CYCLES(3)) dut (.*);
    initial forever #10 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (CONVERT_START === 1'b1) begin
            starts <= starts + 1;
            code <= CONVERT_CODE;
        end
        if (cyc == 5000) begin
            fail_count++;
            final_report;
        end
    end
    task final_report;
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h0, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        do begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= '0;
            if (S_AXI_WREADY) S_AXI_WVALID <= '0;
            if (S_AXI_BVALID) begin
                S_AXI_BREADY <= '0;
                brsp = S_AXI_BRESP;
            end
        end while (S_AXI_AWVALID || S_AXI_WVALID || S_AXI_BREADY);
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= '0;
            if (S_AXI_RVALID) begin
                S_AXI_RREADY <= '0;
                rdat = S_AXI_RDATA;
                rrsp = S_AXI_RRESP;
            end
        end while (S_AXI_ARVALID || S_AXI_RREADY);
    endtask : rd
    // waits for a conversion pulse; bounded so a stuck start-up fails
    task ws;
        int n;
        n = starts;
        for (int i = 0; i < 60 && starts == n; i++) @(posedge MCLK);
        chk(starts != n, 1);
    endtask : ws
    task t_regs;
        rd(8'h00); chk(rdat, 32'h0);
        rd(8'h04); chk(rdat, 32'h0);
        rd(8'h08); chk(rrsp, conv_pkg::RESP_SLVERR);
        wr(8'h08, 8'h00); chk(brsp, conv_pkg::RESP_SLVERR);
    endtask : t_regs
    task t_enable;
        wr(8'h04, 8'h5a); repeat (10) @(posedge MCLK);
        chk(brsp, conv_pkg::RESP_OKAY);
        chk(starts, 0);
        chk(CONVERTER_POWER, 0);
        wr(8'h00, 8'h01); ws;
        chk(code, 8'h5a);
        chk(INTERNAL_OUT_VALID, 1);
        chk(PIN_DRIVE_EN, 0);
        wr(8'h04, 8'ha5); ws;
        chk(code, 8'ha5);
        rd(8'h04); chk(rdat, 32'ha5);
    endtask : t_enable
    task t_mask;
        wr(8'h00, 8'hff); rd(8'h00); chk(rdat, 32'hc1);
        repeat (10) @(posedge MCLK);
        chk(PIN_DRIVE_EN, 1);
    endtask : t_mask
    task t_standby;
        wr(8'h00, 8'h41); STANDBY_SLEEP <= '1; repeat (5) @(posedge MCLK);
        chk({CONVERTER_POWER, BUFFER_POWER}, 0);
        STANDBY_SLEEP <= '0; ws;
        chk(BUFFER_POWER, 1);
    endtask : t_standby
    task t_keep;
        wr(8'h00, 8'hc1); repeat (10) @(posedge MCLK);
        {STANDBY_SLEEP, DEBUG_HALT} <= 2'h3; repeat (5) @(posedge MCLK);
        chk({CONVERTER_POWER, BUFFER_POWER}, 3);
        chk(PIN_DRIVE_EN, 1);
        POWERDOWN_SLEEP <= '1; repeat (5) @(posedge MCLK);
        chk({CONVERTER_POWER, BUFFER_POWER}, 0);
        {STANDBY_SLEEP, POWERDOWN_SLEEP, DEBUG_HALT} <= 3'h0; ws;
        wr(8'h00, 8'h00); repeat (3) @(posedge MCLK);
        chk(CONVERTER_POWER, 0);
    endtask : t_keep
    initial begin
        repeat (10) @(posedge MCLK);
        SRST <= '0;
        t_regs;
        t_enable;
        t_mask;
        t_standby;
        t_keep;
        final_report;
    end
endmodule : dac_control_logic_tb
`default_nettype wire
